// *** hdl/hb_diag_pkg.sv ***
package hb_diag_pkg;

    // =====================================================================
    // spi frame layout, 16 bits, msb first
    // =====================================================================
    localparam int FRAME_BITS   = 16;
    localparam int CMD_ADDR_MSB = 15;
    localparam int CMD_ADDR_LSB = 12;
    localparam int CMD_WR_BIT   = 11;
    localparam int CMD_DATA_W   = 11;
    localparam int STATUS_W     = 12;
    localparam int NUM_SR       = 8;
    localparam int NUM_CH       = 7;

    // =====================================================================
    // control register addresses
    // =====================================================================
    localparam logic [3:0] ADDR_MAIN_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_CFG_FIRST    = 4'h5;
    localparam logic [3:0] ADDR_CFG_LAST     = 4'hb;
    localparam logic [3:0] ADDR_TEST_CURRENT = 4'hc;
    localparam logic [3:0] ADDR_DEGLITCH     = 4'he;
    localparam logic [3:0] ADDR_FACTORY_TEST = 4'hf;

    // main control register fields
    localparam int MAIN_PERSIST_BIT = 3;
    localparam int MAIN_SEL_MSB     = 2;

    // configuration b fields
    localparam int CFGB_SELECT_BIT = 10;
    localparam int CFGB_VDS_LSB    = 7;
    localparam int CFGB_DLY_LSB    = 3;
    localparam int CFGB_SLEW_LSB   = 0;

    // test current fields
    localparam int TST_LOW_LSB  = 4;
    localparam int TST_HIGH_LSB = 0;

    // =====================================================================
    // status registers
    // =====================================================================
    localparam logic [2:0] SR_DEVICE   = 3'h0;
    localparam logic [2:0] SR_OUTPUT   = 3'h5;
    localparam logic [2:0] SR_UNUSED   = 3'h6;
    localparam int         SR0_RCF_BIT  = 10;
    localparam int         SR0_SPIF_BIT = 8;
    localparam logic [11:0] SR5_LIVE_MASK = 12'h00f;

    // reset values
    localparam logic [2:0] RST_VDS  = 3'h0;
    localparam logic [3:0] RST_DLY  = 4'h0;
    localparam logic [2:0] RST_SLEW = 3'h0;

    typedef struct packed {
        logic [2:0] sense_threshold_sel;
        logic [3:0] overload_delay_sel;
        logic [2:0] slew_current_sel;
    } chan_cfg_b_t;

    typedef struct packed {
        logic [2:0]  addr;
        logic        normal_mode_flag;
        logic [11:0] data;
    } status_frame_t;

    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b00,
        LINK_FRAME = 2'b01
    } link_state_t;

endpackage

// *** hdl/halfbridge_spi_config_diag.sv ***
// Overview of operation
// - threshold code 000..111 selects 300..1000 mV
// - delay code 0000..1111 selects 1.05..10.05 us
// - slew current code selects 1.5..25.5 mA
// - d7..d4 enable low-side test currents
// - d3..d0 enable high-side test currents, reset off
// - per-channel de-glitch type bit, reset zero
// - response: address bits 15..13, normal mode flag bit 12, data 11..0
// - unused status address returns zero data
// - main control selects next returned status register
// - persist off: one read, then device status
// - persist on: keep address until rewritten
// - reset clears persist bit and address
// - status bits reset to zero
// - normal mode flag in every frame
// - cleared flag set entering normal, cleared by read
// - all latched except output status low nibble
// - latched bit clears after fault gone and read
module halfbridge_spi_config_diag (
    input  wire logic                                 ref_clk,
    input  wire logic                                 reset,
    input  wire logic                                 spi_sclk,
    input  wire logic                                 spi_cs_n,
    input  wire logic                                 spi_mosi,
    output logic                                      spi_miso,
    output logic                                      spi_miso_oe,
    input  wire logic [hb_diag_pkg::NUM_SR-1:0][11:0] status_raw,
    input  wire logic                                 normal_mode,
    input  wire logic                                 regs_init_done,
    output hb_diag_pkg::chan_cfg_b_t [6:0]            chan_cfg_b,
    output logic [3:0]                                low_side_test_current_en,
    output logic [3:0]                                high_side_test_current_en,
    output logic [6:0]                                deglitch_type_sel
);

    // =====================================================================
    // link input synchronisers
    // =====================================================================
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [1:0] mosi_sync;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sclk_sync <= 3'h0;
            cs_sync   <= 3'h7;
            mosi_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], spi_sclk};
            cs_sync   <= {cs_sync[1:0], spi_cs_n};
            mosi_sync <= {mosi_sync[0], spi_mosi};
        end
    end

    // stages 1 and 2 only are compared, stage 0 feeds stage 1 alone
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;

    assign sclk_rise   = sclk_sync[1] & ~sclk_sync[2];
    assign sclk_fall   = ~sclk_sync[1] & sclk_sync[2];
    assign frame_start = ~cs_sync[1] & cs_sync[2];
    assign frame_end   = cs_sync[1] & ~cs_sync[2];

    // =====================================================================
    // frame engine
    // =====================================================================
    hb_diag_pkg::link_state_t link_state_reg;
    logic [15:0]              rx_reg;
    logic [15:0]              tx_reg;
    logic [4:0]               bit_cnt_reg;
    logic [2:0]               sent_addr_reg;
    logic                     frame_ok;
    logic [2:0]               cur_sel_reg;
    logic                     persist_reg;
    hb_diag_pkg::status_frame_t tx_frame;

    assign frame_ok = (link_state_reg == hb_diag_pkg::LINK_FRAME) && frame_end &&
                      (bit_cnt_reg == 5'(hb_diag_pkg::FRAME_BITS));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            link_state_reg <= hb_diag_pkg::LINK_IDLE;
            rx_reg         <= 16'h0000;
            tx_reg         <= 16'h0000;
            bit_cnt_reg    <= 5'h00;
            sent_addr_reg  <= 3'h0;
            spi_miso       <= 1'b0;
            spi_miso_oe    <= 1'b0;
        end else begin
            case (link_state_reg)
                hb_diag_pkg::LINK_IDLE: begin
                    if (frame_start) begin
                        link_state_reg <= hb_diag_pkg::LINK_FRAME;
                        tx_reg         <= {tx_frame[14:0], 1'b0};
                        spi_miso       <= tx_frame[15];
                        spi_miso_oe    <= 1'b1;
                        sent_addr_reg  <= cur_sel_reg;
                        bit_cnt_reg    <= 5'h00;
                    end
                end
                hb_diag_pkg::LINK_FRAME: begin
                    if (frame_end) begin
                        link_state_reg <= hb_diag_pkg::LINK_IDLE;
                        spi_miso_oe    <= 1'b0;
                    end else begin
                        if (sclk_rise) begin
                            rx_reg <= {rx_reg[14:0], mosi_sync[1]};
                            if (bit_cnt_reg != 5'h1f) begin
                                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                            end
                        end
                        if (sclk_fall) begin
                            spi_miso <= tx_reg[15];
                            tx_reg   <= {tx_reg[14:0], 1'b0};
                        end
                    end
                end
                default: link_state_reg <= hb_diag_pkg::LINK_IDLE;
            endcase
        end
    end

    // =====================================================================
    // write decode
    // =====================================================================
    logic [3:0]  wr_addr;
    logic [10:0] wr_data;
    logic        wr_strobe;

    assign wr_addr   = rx_reg[hb_diag_pkg::CMD_ADDR_MSB:hb_diag_pkg::CMD_ADDR_LSB];
    assign wr_data   = rx_reg[hb_diag_pkg::CMD_DATA_W-1:0];
    assign wr_strobe = frame_ok & rx_reg[hb_diag_pkg::CMD_WR_BIT];

    function automatic logic is_cfg_b(input logic [3:0] a, input logic [10:0] d);
        is_cfg_b = (a >= hb_diag_pkg::ADDR_CFG_FIRST) && (a <= hb_diag_pkg::ADDR_CFG_LAST) &&
                   d[hb_diag_pkg::CFGB_SELECT_BIT];
    endfunction

    // per-channel configuration b; one process, since the channels share one packed output
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int ch = 0; ch < hb_diag_pkg::NUM_CH; ch++) begin
                chan_cfg_b[ch].sense_threshold_sel <= hb_diag_pkg::RST_VDS;
                chan_cfg_b[ch].overload_delay_sel  <= hb_diag_pkg::RST_DLY;
                chan_cfg_b[ch].slew_current_sel    <= hb_diag_pkg::RST_SLEW;
            end
        end else begin
            for (int ch = 0; ch < hb_diag_pkg::NUM_CH; ch++) begin
                if (wr_strobe && is_cfg_b(wr_addr, wr_data) &&
                    wr_addr == 4'(hb_diag_pkg::ADDR_CFG_FIRST + 4'(ch))) begin
                    chan_cfg_b[ch].sense_threshold_sel <= wr_data[hb_diag_pkg::CFGB_VDS_LSB +: 3];
                    chan_cfg_b[ch].overload_delay_sel  <= wr_data[hb_diag_pkg::CFGB_DLY_LSB +: 4];
                    chan_cfg_b[ch].slew_current_sel    <= wr_data[hb_diag_pkg::CFGB_SLEW_LSB +: 3];
                end
            end
        end
    end

    // factory test address has its own branch that only holds deglitch_type_sel: no effect
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            low_side_test_current_en  <= 4'h0;
            high_side_test_current_en <= 4'h0;
            deglitch_type_sel         <= 7'h00;
        end else if (wr_strobe) begin
            if (wr_addr == hb_diag_pkg::ADDR_TEST_CURRENT) begin
                low_side_test_current_en  <= wr_data[hb_diag_pkg::TST_LOW_LSB +: 4];
                high_side_test_current_en <= wr_data[hb_diag_pkg::TST_HIGH_LSB +: 4];
            end else if (wr_addr == hb_diag_pkg::ADDR_DEGLITCH) begin
                deglitch_type_sel <= wr_data[6:0];
            end else if (wr_addr == hb_diag_pkg::ADDR_FACTORY_TEST) begin
                deglitch_type_sel <= deglitch_type_sel;
            end
        end
    end

    // =====================================================================
    // status address selection
    // =====================================================================
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cur_sel_reg <= hb_diag_pkg::SR_DEVICE;
            persist_reg <= 1'b0;
        end else if (wr_strobe && wr_addr == hb_diag_pkg::ADDR_MAIN_CTRL) begin
            cur_sel_reg <= wr_data[hb_diag_pkg::MAIN_SEL_MSB:0];
            persist_reg <= wr_data[hb_diag_pkg::MAIN_PERSIST_BIT];
        end else if (frame_ok && !persist_reg) begin
            cur_sel_reg <= hb_diag_pkg::SR_DEVICE;
        end
    end

    // =====================================================================
    // latched diagnosis
    // =====================================================================
    logic [hb_diag_pkg::NUM_SR-1:0][11:0] lat_reg;
    logic                                 rcf_reg;
    logic                                 spif_reg;
    logic                                 nm_prev_reg;
    logic                                 spi_fail;

    assign spi_fail = (link_state_reg == hb_diag_pkg::LINK_FRAME) && frame_end &&
                      (bit_cnt_reg != 5'(hb_diag_pkg::FRAME_BITS));

    // a read reloads from the live fault, so a bit only drops when both
    // the fault is gone and it was read; a fault in that cycle survives
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            lat_reg <= '0;
        end else begin
            for (int k = 0; k < hb_diag_pkg::NUM_SR; k++) begin
                if (frame_ok && sent_addr_reg == 3'(k)) begin
                    lat_reg[k] <= status_raw[k];
                end else begin
                    lat_reg[k] <= lat_reg[k] | status_raw[k];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rcf_reg     <= 1'b0;
            spif_reg    <= 1'b0;
            nm_prev_reg <= 1'b0;
        end else begin
            nm_prev_reg <= normal_mode;
            if (normal_mode && !nm_prev_reg && regs_init_done) begin
                rcf_reg <= 1'b1;
            end else if (frame_ok && sent_addr_reg == hb_diag_pkg::SR_DEVICE) begin
                rcf_reg <= 1'b0;
            end
            if (spi_fail) begin
                spif_reg <= 1'b1;
            end else if (frame_ok && sent_addr_reg == hb_diag_pkg::SR_DEVICE) begin
                spif_reg <= 1'b0;
            end
        end
    end

    // =====================================================================
    // response frame
    // =====================================================================
    always_comb begin
        tx_frame.addr             = cur_sel_reg;
        tx_frame.normal_mode_flag = normal_mode;
        tx_frame.data             = lat_reg[cur_sel_reg];
        if (cur_sel_reg == hb_diag_pkg::SR_DEVICE) begin
            tx_frame.data[hb_diag_pkg::SR0_RCF_BIT]  = rcf_reg;
            tx_frame.data[hb_diag_pkg::SR0_SPIF_BIT] = spif_reg;
        end else if (cur_sel_reg == hb_diag_pkg::SR_OUTPUT) begin
            tx_frame.data = (lat_reg[cur_sel_reg] & ~hb_diag_pkg::SR5_LIVE_MASK) |
                            (status_raw[cur_sel_reg] & hb_diag_pkg::SR5_LIVE_MASK);
        end else if (cur_sel_reg == hb_diag_pkg::SR_UNUSED) begin
            tx_frame.data = 12'h000;
        end
    end

endmodule

// *** sim/hb_diag_assertions.sv ***
module hb_diag_assertions (
    input wire logic                           ref_clk,
    input wire logic                           reset,
    input wire logic                           spi_sclk,
    input wire logic                           spi_cs_n,
    input wire logic                           spi_miso,
    input wire logic                           spi_miso_oe,
    input wire hb_diag_pkg::chan_cfg_b_t [6:0] chan_cfg_b,
    input wire logic [3:0]                     low_side_test_current_en,
    input wire logic [3:0]                     high_side_test_current_en,
    input wire logic [6:0]                     deglitch_type_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // =====================================================================
    // helper: cycles since chip select went high, saturating
    // =====================================================================
    logic [3:0] cs_high_cnt_reg;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset)
            cs_high_cnt_reg <= 4'h0;
        else if (!spi_cs_n)
            cs_high_cnt_reg <= 4'h0;
        else if (cs_high_cnt_reg != 4'hf)
            cs_high_cnt_reg <= cs_high_cnt_reg + 4'h1;
    end
    property p_oe_idle; cs_high_cnt_reg >= 4'h6 |-> !spi_miso_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("miso driven outside frame");
    property p_oe_frame; !spi_cs_n [*7] |-> spi_miso_oe; endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("miso not driven in frame");
    property p_oe_rose; $rose(spi_miso_oe) |-> !spi_cs_n && !$past(spi_cs_n, 2); endproperty
    a_oe_rose: assert property (p_oe_rose) else $error("miso enabled without select");
    // sclk low at a shift: miso must move only after a falling sclk edge
    property p_miso_shift; spi_miso_oe && $past(spi_miso_oe) && $changed(spi_miso) |-> !spi_sclk; endproperty
    a_miso_shift: assert property (p_miso_shift) else $error("miso moved while sclk high");
    property p_reset_vals;
        $fell(reset) |-> chan_cfg_b == '0 && low_side_test_current_en == 4'h0
            && high_side_test_current_en == 4'h0 && deglitch_type_sel == 7'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("config not zero after reset");
    property p_cfg_hold; $changed(chan_cfg_b) |=> $stable(chan_cfg_b) [*8]; endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed twice quickly");
    property p_test_cur; $changed(low_side_test_current_en) |-> spi_cs_n && !$past(spi_cs_n, 10); endproperty
    a_test_cur: assert property (p_test_cur) else $error("test current changed off frame end");
    property p_deglitch; $changed(deglitch_type_sel) |-> spi_cs_n && $past(spi_cs_n, 2); endproperty
    a_deglitch: assert property (p_deglitch) else $error("deglitch changed inside frame");
    c_cfg: cover property ($changed(chan_cfg_b));
    c_frame: cover property ($rose(spi_miso_oe));
    c_dgl: cover property ($changed(deglitch_type_sel));
endmodule

bind halfbridge_spi_config_diag hb_diag_assertions u_hb_diag_assertions (.ref_clk, .reset, .spi_sclk, .spi_cs_n,
    .spi_miso, .spi_miso_oe, .chan_cfg_b, .low_side_test_current_en, .high_side_test_current_en, .deglitch_type_sel);

// *** sim/spi_host_model.sv ***
module spi_host_model (
    output logic     spi_sclk,
    output logic     spi_cs_n,
    output logic     spi_mosi,
    input wire logic spi_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // sclk stands low between frames, mode 0
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // odd start offset keeps the link unrelated in phase to ref_clk
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        #1.3 spi_cs_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_mosi <= tx[15 - i];
            #24 spi_sclk <= 1'b1;
            rx = {rx[14:0], spi_miso};
            #24 spi_sclk <= 1'b0;
        end
        #24 spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        #96;
    endtask
endmodule

// *** sim/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                                 ref_clk;
    logic                                 reset;
    logic                                 spi_sclk;
    logic                                 spi_cs_n;
    logic                                 spi_mosi;
    logic                                 spi_miso;
    logic                                 spi_miso_oe;
    logic [hb_diag_pkg::NUM_SR-1:0][11:0] status_raw;
    logic                                 normal_mode;
    logic                                 regs_init_done;
    hb_diag_pkg::chan_cfg_b_t [6:0]       chan_cfg_b;
    logic [3:0]                           low_side_test_current_en;
    logic [3:0]                           high_side_test_current_en;
    logic [6:0]                           deglitch_type_sel;
    logic [15:0]                          rx;
    logic [9:0]                           cfg [7];
    int                                   mismatches;
    int                                   num_checks;
    int                                   cycles;

    halfbridge_spi_config_diag u_halfbridge_spi_config_diag (.ref_clk, .reset, .spi_sclk, .spi_cs_n, .spi_mosi,
        .spi_miso, .spi_miso_oe, .status_raw, .normal_mode, .regs_init_done, .chan_cfg_b,
        .low_side_test_current_en, .high_side_test_current_en, .deglitch_type_sel);
    spi_host_model u_spi_host_model (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);

    // =====================================================================
    // clock, timeout and reporting
    // =====================================================================
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // a full run is about 4400 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        u_spi_host_model.xfer({a, 1'b1, d}, 16, rx);
    endtask
    // address 1 without the write flag: a read that writes no control register
    task automatic rd_chk(input logic [15:0] exp);
        u_spi_host_model.xfer(16'h1000, 16, rx);
        check(rx, exp);
    endtask

    // =====================================================================
    // test sequence
    // =====================================================================
    initial begin
        reset = 1'b1;
        normal_mode = 1'b0;
        regs_init_done = 1'b0;
        status_raw = '0;
        mismatches = 0;
        num_checks = 0;
        cycles = 0;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        for (int c = 0; c < 7; c++) check(16'(chan_cfg_b[c]), 16'h0000);
        check({low_side_test_current_en, high_side_test_current_en, 1'b0, deglitch_type_sel}, 16'h0000);
        normal_mode <= 1'b1;
        regs_init_done <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd_chk(16'h1400);
        rd_chk(16'h1000);
        for (int c = 0; c < 7; c++) begin
            cfg[c] = (c == 0) ? 10'h3ff : {3'(c), 4'(15 - 2 * c), 3'(7 - c)};
            wr(4'(5 + c), {1'b1, cfg[c]});
        end
        wr(4'h5, 11'h000);
        wr(4'hc, 11'h0a5);
        wr(4'he, 11'h055);
        wr(4'hf, 11'h7ff);
        for (int c = 0; c < 7; c++) check(16'(chan_cfg_b[c]), 16'(cfg[c]));
        check(16'(low_side_test_current_en), 16'h000a);
        check(16'(high_side_test_current_en), 16'h0005);
        check(16'(deglitch_type_sel), 16'h0055);
        wr(4'h0, 11'h00d);
        @(posedge ref_clk) status_raw[5] <= 12'h0f3;
        repeat (4) @(posedge ref_clk);
        status_raw[5] <= 12'h000;
        repeat (4) @(posedge ref_clk);
        rd_chk(16'hb0f0);
        rd_chk(16'hb000);
        wr(4'h0, 11'h006);
        check(rx, 16'hb000);
        @(posedge ref_clk) status_raw[6] <= 12'hfff;
        rd_chk(16'hd000);
        rd_chk(16'h1000);
        @(posedge ref_clk) status_raw[6] <= 12'h000;
        // a short frame must neither write nor clear anything
        u_spi_host_model.xfer(16'hc8ff, 8, rx);
        rd_chk(16'h1100);
        check(16'(low_side_test_current_en), 16'h000a);
        @(posedge ref_clk) normal_mode <= 1'b0;
        rd_chk(16'h0000);
        @(posedge ref_clk) normal_mode <= 1'b1;
        rd_chk(16'h1400);
        wr(4'h0, 11'h00d);
        @(posedge ref_clk) reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(16'(chan_cfg_b[0]), 16'h0000);
        check({low_side_test_current_en, high_side_test_current_en, 1'b0, deglitch_type_sel}, 16'h0000);
        u_spi_host_model.xfer(16'h1000, 16, rx);
        check(16'(rx[15:13]), 16'h0000);
        summarize();
    end
endmodule
